// file: rtl/c8b_codec.sv
// 8B/10B character codec: transmit FIFO, encoder, serializer, aligner, decoder
`timescale 1ns/10ps
`include "c8b_cfg.svh"
// How it works
// - Each byte becomes one ten-bit character, shifted out one bit per cycle.
// - Received bits are grouped in tens; each group decodes back to a byte.
// - All 256 byte values encode to valid data characters.
// - Byte bit 0 is letter A up to bit 7 as H; a..h follow A..H.
// - Bit i depends on A to E only, bit j on F to H and also on A to E, through the sub-block disparity and the A7 choice.
// - Select low means data character, select high means special character.
// - Data name Dxx.y: xx is bits EDCBA, y is bits HGF.
// - Comma pattern in the received stream sets the character boundary.
// - Serial order is a, b, c, d, e, i, f, g, h, j; a first.
// - Sub-block disparity goes positive, negative or holds per ones count.
// - Character missing from its disparity column flags violation, still updates disparity.

// ==========================================================
// Transmit FIFO
module c8b_fifo #(
   parameter int W     = 9,
   parameter int DEPTH = 4
) (
   input  logic         clk,       // Character clock
   input  logic         rst_n,     // Async reset, active low
   input  logic         ce,        // Clock enable
   input  logic         in_valid,  // Write request
   output logic         in_ready,  // Room for a word
   input  logic [W-1:0] in_data,   // Write word
   output logic         out_valid, // Word available
   input  logic         out_ready, // Read request
   output logic [W-1:0] out_data   // Head word
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   logic [W-1:0]  mem_reg [DEPTH];
   logic [AW-1:0] wr_reg;
   logic [AW-1:0] rd_reg;
   logic [CW-1:0] cnt_reg;
   logic [CW-1:0] cnt_next;
   logic          in_ready_reg;
   logic          push;
   logic          pop;

   assign push      = ce && in_valid && in_ready_reg;
   assign pop       = ce && out_ready && out_valid;
   assign out_valid = cnt_reg != CW'(0);
   assign out_data  = mem_reg[rd_reg];
   assign in_ready  = in_ready_reg;
   assign cnt_next  = cnt_reg + CW'(push) - CW'(pop);

   function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] p);
      return (p == AW'(DEPTH - 1)) ? AW'(0) : p + AW'(1);
   endfunction : wrap_inc

   always_ff @(posedge clk) begin
      if (push) begin
         mem_reg[wr_reg] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_reg       <= '0;
         rd_reg       <= '0;
         cnt_reg      <= '0;
         in_ready_reg <= 1'b0;
      end else if (ce) begin
         if (push) wr_reg <= wrap_inc(wr_reg);
         if (pop) rd_reg <= wrap_inc(rd_reg);
         cnt_reg      <= cnt_next;
         // Registered so the host sees ready straight from a flop
         in_ready_reg <= cnt_next != CW'(DEPTH);
      end
   end

   default clocking fcb @(posedge clk); endclocking
   default disable iff (!rst_n);

   fifo_full_a: assert property (cnt_reg == CW'(DEPTH) |-> !in_ready_reg)
      else $error("fifo accepts while full");
   fifo_fill_c: cover property (cnt_reg == CW'(DEPTH));
endmodule : c8b_fifo

// ==========================================================
// Codec top
module c8b_codec (
   input  logic              clk,       // Character clock, 200 MHz
   input  logic              rst_n,     // Async reset, active low
   input  logic              ce,        // Clock enable, freezes all state
   input  c8b_pkg::c8b_sym_t tx_sym,    // Byte and special select to send
   input  logic              tx_valid,  // Byte offered
   output logic              tx_ready,  // FIFO has room
   output logic              tx_serial, // Serial line out
   input  logic              rx_serial, // Serial line in, asynchronous
   output c8b_pkg::c8b_rx_t  rx_char,   // Decoded byte, select, violation
   output logic              rx_valid,  // One-cycle char strobe
   output logic              rx_aligned // Boundary found by comma
);
   import c8b_pkg::*;

   // =======================================================
   // Code tables, written for negative running disparity
   localparam logic [5:0] TBL6 [32] = '{
      6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
      6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
      6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
      6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
   localparam logic [3:0] TBL4 [8] = '{
      4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};

   function automatic logic flip6(input logic [5:0] s);
      return $countones(s) != 3 || s == `C8B_SIX_NEG;
   endfunction : flip6

   function automatic logic flip4(input logic [3:0] f);
      return $countones(f) != 2 || f == `C8B_FOUR_NEG;
   endfunction : flip4

   function automatic logic rd6(input logic rd, input logic [5:0] s);
      if ($countones(s) > 3 || s == `C8B_SIX_POS) return 1'b1;
      if ($countones(s) < 3 || s == `C8B_SIX_NEG) return 1'b0;
      return rd;
   endfunction : rd6

   function automatic logic rd4(input logic rd, input logic [3:0] f);
      if ($countones(f) > 2 || f == `C8B_FOUR_POS) return 1'b1;
      if ($countones(f) < 2 || f == `C8B_FOUR_NEG) return 1'b0;
      return rd;
   endfunction : rd4

   function automatic logic rd_after(input logic [9:0] c, input logic rd);
      return rd4(rd6(rd, c[9:4]), c[3:0]);
   endfunction : rd_after

   // Code word layout is {a,b,c,d,e,i,f,g,h,j}, a in the top bit
   function automatic logic [9:0] enc(input logic [7:0] d, input logic k,
                                      input logic rd);
      logic [4:0] x;
      logic [2:0] y;
      logic       k28;
      logic       re;
      logic       rm;
      logic       alt;
      logic [5:0] s;
      logic [3:0] f;
      x   = d[4:0];
      y   = d[7:5];
      k28 = k && x == `C8B_X28;
      // K28 columns are exact complements, so build the negative one
      re  = rd && !k28;
      s   = k28 ? `C8B_K28_6B : TBL6[x];
      if (re && flip6(s)) s = ~s;
      rm  = rd6(re, s);
      alt = y == `C8B_Y7 && (k || (!rm && (x == 5'h11 || x == 5'h12 ||
            x == 5'h14)) || (rm && (x == 5'h0B || x == 5'h0D ||
            x == 5'h0E)));
      f   = alt ? `C8B_ALT_4B : TBL4[y];
      if (rm && flip4(f)) f = ~f;
      return (k28 && rd) ? ~{s, f} : {s, f};
   endfunction : enc

   function automatic c8b_rx_t dec(input logic [9:0] c, input logic rd);
      c8b_rx_t    r;
      logic [5:0] s;
      logic [3:0] ff;
      logic [4:0] x;
      logic [2:0] y;
      logic       k28;
      logic       a7;
      s   = c[9:4];
      x   = '0;
      y   = '0;
      for (int i = 0; i < 32; i++) begin
         if (s == TBL6[i] || (s == ~TBL6[i] && flip6(TBL6[i]))) x = 5'(i);
      end
      k28 = s == `C8B_K28_6B || s == ~`C8B_K28_6B;
      if (k28) x = `C8B_X28;
      ff  = (s == ~`C8B_K28_6B) ? ~c[3:0] : c[3:0];
      for (int i = 0; i < 8; i++) begin
         if (ff == TBL4[i] || (ff == ~TBL4[i] && flip4(TBL4[i]))) y = 3'(i);
      end
      a7  = ff == `C8B_ALT_4B || ff == ~`C8B_ALT_4B;
      if (a7) y = `C8B_Y7;
      r.data                = {y, x};
      r.special_char_select = k28 || (a7 && (x == 5'h17 || x == 5'h1B ||
                              x == 5'h1D || x == 5'h1E));
      // Re-encode against the current column to catch any mismatch
      r.code_violation      = enc(r.data, r.special_char_select, rd) != c;
      return r;
   endfunction : dec

   // =======================================================
   // Transmit path
   c8b_sym_t              fifo_data;
   c8b_sym_t              tx_cur;
   logic                  fifo_valid;
   logic                  tx_load;
   logic [9:0]            tx_code;
   logic [`C8B_CNT_W-1:0] tx_cnt_reg;
   logic [9:0]            tx_sh_reg;
   logic                  tx_ser_reg;
   logic                  tx_rd_reg;

   // Serializer pops exactly when the last bit of a character leaves
   assign tx_load = ce && tx_cnt_reg == `C8B_LAST_BIT;

   c8b_fifo #(
      .W     ($bits(c8b_sym_t)),
      .DEPTH (`C8B_FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .rst_n     (rst_n),
      .ce        (ce),
      .in_valid  (tx_valid),
      .in_ready  (tx_ready),
      .in_data   (tx_sym),
      .out_valid (fifo_valid),
      .out_ready (tx_load),
      .out_data  (fifo_data)
   );

   // An empty FIFO sends the comma idle so the far end stays aligned
   assign tx_cur  = fifo_valid ? fifo_data : c8b_sym_t'({1'b1, `C8B_IDLE_BYTE});
   assign tx_code = enc(tx_cur.data, tx_cur.special_char_select, tx_rd_reg);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_cnt_reg <= `C8B_LAST_BIT;
      end else if (ce) begin
         tx_cnt_reg <= tx_load ? `C8B_CNT_ZERO : tx_cnt_reg + `C8B_CNT_ONE;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_sh_reg  <= '0;
         tx_ser_reg <= 1'b0;
      end else if (tx_load) begin
         tx_ser_reg <= tx_code[9];
         tx_sh_reg  <= {tx_code[8:0], 1'b0};
      end else if (ce) begin
         tx_ser_reg <= tx_sh_reg[9];
         tx_sh_reg  <= {tx_sh_reg[8:0], 1'b0};
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_rd_reg <= `C8B_RD_RESET;
      end else if (tx_load) begin
         tx_rd_reg <= rd_after(tx_code, tx_rd_reg);
      end
   end

   assign tx_serial = tx_ser_reg;

   // =======================================================
   // Receive path
   logic                  rx_s1_reg;
   logic                  rx_s2_reg;
   logic [9:0]            rx_sh_reg;
   logic [9:0]            rx_win;
   logic                  rx_comma;
   logic                  rx_done;
   logic [`C8B_CNT_W-1:0] rx_cnt_reg;
   logic                  rx_al_reg;
   logic                  rx_val_reg;
   logic                  rx_rd_reg;
   c8b_rx_t               rx_out_reg;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_s1_reg <= 1'b0;
         rx_s2_reg <= 1'b0;
      end else if (ce) begin
         rx_s1_reg <= rx_serial;
         rx_s2_reg <= rx_s1_reg;
      end
   end

   assign rx_win   = {rx_sh_reg[8:0], rx_s2_reg};
   assign rx_comma = rx_win[9:3] == `C8B_COMMA_POS ||
                     rx_win[9:3] == `C8B_COMMA_NEG;
   // A comma restarts the count even mid-character, realigning the stream
   assign rx_done  = rx_comma || (rx_al_reg && rx_cnt_reg == `C8B_LAST_BIT);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_sh_reg  <= '0;
         rx_cnt_reg <= `C8B_CNT_ZERO;
         rx_al_reg  <= 1'b0;
      end else if (ce) begin
         rx_sh_reg  <= rx_win;
         rx_al_reg  <= rx_al_reg || rx_comma;
         if (rx_done || rx_cnt_reg == `C8B_LAST_BIT) begin
            rx_cnt_reg <= `C8B_CNT_ZERO;
         end else begin
            rx_cnt_reg <= rx_cnt_reg + `C8B_CNT_ONE;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_val_reg <= 1'b0;
         rx_out_reg <= '0;
         rx_rd_reg  <= `C8B_RD_RESET;
      end else if (ce) begin
         rx_val_reg <= rx_done;
         if (rx_done) begin
            rx_out_reg <= dec(rx_win, rx_rd_reg);
            rx_rd_reg  <= rd_after(rx_win, rx_rd_reg);
         end
      end
   end

   assign rx_char    = rx_out_reg;
   assign rx_valid   = rx_val_reg;
   assign rx_aligned = rx_al_reg;

   // =======================================================
   // Checks
   // Function results are held on nets, since a call cannot be indexed or member-selected
   c8b_rx_t    tx_chk;
   logic [9:0] tx_iref;

   assign tx_chk  = dec(tx_code, tx_rd_reg);
   assign tx_iref = enc({3'h0, tx_cur.data[4:0]}, 1'b0, tx_rd_reg);

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   tx_roundtrip_a: assert property (tx_load |->
      !tx_chk.code_violation &&
      tx_chk.data == tx_cur.data)
      else $error("encoded character does not decode back");
   tx_first_a: assert property (tx_load |=> tx_ser_reg == $past(tx_code[9]))
      else $error("bit a not sent first");
   tx_count_a: assert property (ce && !tx_load |=>
      tx_cnt_reg == $past(tx_cnt_reg) + `C8B_CNT_ONE)
      else $error("serializer count skipped");
   tx_ibit_a: assert property (tx_load && !tx_cur.special_char_select |->
      tx_code[4] == tx_iref[4])
      else $error("bit i depends on F to H");
   tx_disp_a: assert property (tx_load |=> (tx_rd_reg != $past(tx_rd_reg)) ==
      ($countones($past(tx_code)) != 5))
      else $error("disparity step wrong");
   rx_align_a: assert property (ce && rx_comma |=>
      rx_al_reg && rx_val_reg && rx_cnt_reg == `C8B_CNT_ZERO)
      else $error("comma did not set boundary");
   rx_decode_a: assert property ($past(ce) && rx_val_reg &&
      !rx_out_reg.code_violation |-> enc(rx_out_reg.data,
      rx_out_reg.special_char_select, $past(rx_rd_reg)) == rx_sh_reg)
      else $error("decoded byte wrong");
   rx_viol_a: assert property ($past(ce) && rx_val_reg &&
      rx_out_reg.code_violation |->
      rx_rd_reg == rd_after(rx_sh_reg, $past(rx_rd_reg)))
      else $error("disparity not updated on violation");
   rx_kname_a: assert property (rx_val_reg && rx_out_reg.special_char_select &&
      !rx_out_reg.code_violation |-> rx_out_reg.data[4:0] == `C8B_X28 ||
      rx_out_reg.data[7:5] == `C8B_Y7)
      else $error("special character name invalid");

   tx_data_c: cover property (tx_load && fifo_valid);
   tx_idle_c: cover property (tx_load && !fifo_valid);
   rx_viol_c: cover property (rx_val_reg && rx_out_reg.code_violation);
   rx_data_c: cover property (rx_val_reg && !rx_out_reg.special_char_select);
endmodule : c8b_codec

// file: shared/c8b_cfg.svh
// Constants of the 8B/10B character codec
`ifndef C8B_CFG_SVH
`define C8B_CFG_SVH
`define C8B_BYTE_W     8
`define C8B_CHAR_W     10
`define C8B_FIFO_DEPTH 4
`define C8B_CNT_W      4
`define C8B_LAST_BIT   4'h9
`define C8B_CNT_ZERO   4'h0
`define C8B_CNT_ONE    4'h1
`define C8B_RD_RESET   1'b0
`define C8B_K28_6B     6'h0F
`define C8B_X28        5'h1C
`define C8B_Y7         3'h7
`define C8B_ALT_4B     4'h7
`define C8B_SIX_POS    6'h07
`define C8B_SIX_NEG    6'h38
`define C8B_FOUR_POS   4'h3
`define C8B_FOUR_NEG   4'hC
`define C8B_IDLE_BYTE  8'hBC
`define C8B_COMMA_POS  7'h1F
`define C8B_COMMA_NEG  7'h60
`endif

// file: shared/c8b_pkg.sv
// Types shared by the 8B/10B character codec
package c8b_pkg;
`include "c8b_cfg.svh"
   typedef struct packed {
      logic                     special_char_select;
      logic [`C8B_BYTE_W-1:0]   data;
   } c8b_sym_t;
   typedef struct packed {
      logic                     special_char_select;
      logic                     code_violation;
      logic [`C8B_BYTE_W-1:0]   data;
   } c8b_rx_t;
endpackage : c8b_pkg

// file: test/c8b_link_model.sv
// Serial loop partner: returns the transmit line to the receiver after a delay
`timescale 1ns/10ps
// ==========================================================
// Loop model
module c8b_link_model #(
   parameter int DELAY = 3
) (
   input  logic clk,      // Character clock
   input  logic rst_n,    // Async reset, active low
   input  logic ce,       // Clock enable shared with the codec
   input  logic tx_line,  // Serial line from the codec
   input  logic flip_req, // Invert the bit passing this cycle
   output logic rx_line   // Serial line back to the codec
);
   logic [DELAY-1:0] pipe_reg;

   // Shift only with ce, or a frozen codec would see its own bit repeated on resume
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pipe_reg <= '0;
      end else if (ce) begin
         pipe_reg <= {pipe_reg[DELAY-2:0], tx_line ^ flip_req};
      end
   end

   assign rx_line = pipe_reg[DELAY-1];
endmodule : c8b_link_model

// file: test/tb_code_8b10b_mapping.sv
// Self-checking bench for the 8B/10B codec over a serial loop
`timescale 1ns/10ps
// ==========================================================
// Bench top
module tb_code_8b10b_mapping;
   import c8b_pkg::*;
   logic        clk, rst_n, ce, tx_valid, tx_ready, tx_serial;
   logic        rx_serial, rx_valid, rx_aligned, flip_req, saw_full;
   c8b_sym_t    tx_sym;
   c8b_rx_t     rx_char;
   c8b_rx_t     rxq[$];
   logic [19:0] txwin;
   int          fails = 0;
   int          num_checks = 0;
   int          cycles = 0;

   c8b_codec uut (.clk(clk), .rst_n(rst_n), .ce(ce), .tx_sym(tx_sym), .tx_valid(tx_valid),
      .tx_ready(tx_ready), .tx_serial(tx_serial), .rx_serial(rx_serial), .rx_char(rx_char),
      .rx_valid(rx_valid), .rx_aligned(rx_aligned));
   c8b_link_model #(.DELAY(3)) link (.clk(clk), .rst_n(rst_n), .ce(ce), .tx_line(tx_serial),
      .flip_req(flip_req), .rx_line(rx_serial));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // ==========================================================
   // Monitors and hang guard
   always @(posedge clk) begin
      if (ce === 1'b1) txwin <= {txwin[18:0], tx_serial};
      // Idle commas are filler, so only other characters are queued
      if (rx_valid === 1'b1 && ce === 1'b1 && rx_char !== 10'h2BC) rxq.push_back(rx_char);
      cycles++;
      if (cycles == 20000) begin
         fails++;
         complete_run();
      end
   end

   // ==========================================================
   // Helpers
   task automatic complete_run;
      if (fails == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : complete_run

   task automatic check_bit(input string name, input logic exp, input logic got);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %s expected %b seen %b", name, exp, got);
      end
   endtask : check_bit

   task automatic check_rx(input string name, input c8b_rx_t exp, input c8b_rx_t got);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask : check_rx

   // Holds the offer until taken or 200 cycles pass; leaves tx_valid up for back-to-back use
   task automatic send(input c8b_sym_t sym);
      int n;
      n = 0;
      tx_sym = sym;
      tx_valid = 1'b1;
      do begin
         @(posedge clk);
         if (tx_ready !== 1'b1) saw_full = 1'b1;
         n++;
      end while (!(tx_ready === 1'b1 && ce === 1'b1) && n < 200);
      @(negedge clk);
   endtask : send

   task automatic wait_tx(input string name, input logic [19:0] pat, input int nb, input int lim);
      logic hit;
      hit = 1'b0;
      for (int k = 0; k < lim && !hit; k++) begin
         @(negedge clk);
         hit = (nb == 10) ? (txwin[9:0] === pat[9:0]) : (txwin === pat);
      end
      check_bit(name, 1'b1, hit);
   endtask : wait_tx

   task automatic expect_rx(input string name, input c8b_sym_t sym);
      int n;
      n = 0;
      while (rxq.size() == 0 && n < 400) begin
         @(negedge clk);
         n++;
      end
      if (rxq.size() == 0) check_bit(name, 1'b1, 1'b0);
      else check_rx(name, {sym.special_char_select, 1'b0, sym.data}, rxq.pop_front());
   endtask : expect_rx

   // ==========================================================
   // Scenarios
   task automatic t_reset_idle;
      wait_tx("first idle pair", 20'b0011111010_1100000101, 20, 26);
      for (int k = 0; k < 60 && rx_aligned !== 1'b1; k++) @(negedge clk);
      check_bit("rx_aligned", 1'b1, rx_aligned);
   endtask : t_reset_idle

   task automatic t_d5_2;
      send({1'b0, 8'h45});
      tx_valid = 1'b0;
      wait_tx("D5.2 serial", {10'h000, 10'b1010010101}, 10, 80);
      expect_rx("D5.2 decode", {1'b0, 8'h45});
   endtask : t_d5_2

   task automatic t_all_data;
      saw_full = 1'b0;
      for (int b = 0; b < 256; b++) send({1'b0, b[7:0]});
      tx_valid = 1'b0;
      check_bit("fifo refusal seen", 1'b1, saw_full);
      for (int b = 0; b < 256; b++) expect_rx("data byte", {1'b0, b[7:0]});
      wait_tx("idle after drain", {10'h000, 10'b0011111010}, 10, 80);
   endtask : t_all_data

   task automatic t_specials;
      logic [7:0] ks[11];
      ks = '{8'h1C, 8'h3C, 8'h5C, 8'h7C, 8'h9C, 8'hDC, 8'hFC, 8'hF7, 8'hFB, 8'hFD, 8'hFE};
      foreach (ks[i]) send({1'b1, ks[i]});
      tx_valid = 1'b0;
      foreach (ks[i]) expect_rx("special char", {1'b1, ks[i]});
   endtask : t_specials

   task automatic t_freeze;
      logic hold, stable;
      ce = 1'b0;
      hold = tx_serial;
      stable = 1'b1;
      repeat (20) begin
         @(negedge clk);
         if (tx_serial !== hold) stable = 1'b0;
      end
      check_bit("frozen line", 1'b1, stable);
      ce = 1'b1;
      send({1'b0, 8'h5A});
      tx_valid = 1'b0;
      expect_rx("after freeze", {1'b0, 8'h5A});
   endtask : t_freeze

   task automatic t_violation;
      logic hit;
      hit = 1'b0;
      rxq.delete();
      flip_req = 1'b1;
      @(negedge clk);
      flip_req = 1'b0;
      for (int k = 0; k < 120 && !hit; k++) begin
         @(negedge clk);
         foreach (rxq[i]) if (rxq[i].code_violation === 1'b1) hit = 1'b1;
      end
      check_bit("code violation", 1'b1, hit);
   endtask : t_violation

   // ==========================================================
   // Main sequence
   initial begin
      ce = 1'b1;
      tx_valid = 1'b0;
      tx_sym = '0;
      flip_req = 1'b0;
      saw_full = 1'b0;
      txwin = '0;
      rst_n = 1'b0;
      repeat (10) @(negedge clk);
      rst_n = 1'b1;
      t_reset_idle();
      t_d5_2();
      t_all_data();
      t_specials();
      t_freeze();
      t_violation();
      complete_run();
   end
endmodule : tb_code_8b10b_mapping
